//--- testbench/acl_ctrl_model.sv
// controller end of the link: frame sync, outbound slot data, inbound timing watch
// assumes the bench enables framing only while the codec bit clock runs
`timescale 1ns/1ps
`include "acl_cfg.svh"

module acl_ctrl_model (
    input wire logic bit_clk_i,
    input wire logic oe_i,
    input wire logic sdata_in_i,
    input wire logic en_i,
    input wire logic strap_sync_i,
    input wire logic strap_sdo_i,
    input wire logic [19:0] mono_i,
    output logic sync_o,
    output logic sdata_out_o,
    output logic [15:0] tag_o,
    output logic [19:0] in_l_o,
    output logic [19:0] in_r_o,
    output int bad_cnt_o
);
    logic [7:0] pos = 8'h00;
    logic f_sync = 1'b0;
    logic f_sdo = 1'b0;
    realtime t_chg = 0.0;
    realtime t_fall = -100.0;

    initial bad_cnt_o = 0;
    // launch on the rise so both lines settle long before the sampling fall
    always @(posedge bit_clk_i) begin
        f_sync <= en_i && pos < 8'h10;
        f_sdo <= en_i && (pos inside {[56:75]} ? mono_i[75 - pos] :
            pos inside {[76:95]} ? mono_i[95 - pos] : 1'b0);
        pos <= en_i ? pos + 8'h01 : 8'h00;
    end
    // outside frames the bench strap levels stand in for the controller
    assign sync_o = en_i ? f_sync : strap_sync_i;
    assign sdata_out_o = en_i ? f_sdo : strap_sdo_i;

    always @(sdata_in_i) begin
        if (oe_i && $realtime - t_fall < 5.0) bad_cnt_o++;
        t_chg = $realtime;
    end
    always @(negedge bit_clk_i) begin
        if (oe_i && $realtime - t_chg < 15.0) bad_cnt_o++;
        t_fall = $realtime;
    end
    // the bit sampled at a fall is the one launched when pos last moved past it
    always @(negedge bit_clk_i) begin
        if (en_i && pos >= 8'd1 && pos <= 8'd16) tag_o <= {tag_o[14:0], sdata_in_i};
        if (en_i && pos >= 8'd57 && pos <= 8'd76) in_l_o <= {in_l_o[18:0], sdata_in_i};
        if (en_i && pos >= 8'd77 && pos <= 8'd96) in_r_o <= {in_r_o[18:0], sdata_in_i};
    end
endmodule

//--- testbench/testbench.sv
// self-checking bench for the codec link block with a controller model
// assumes the design files and acl_ctrl_model are compiled first
`timescale 1ns/1ps

module testbench;
    import acl_pkg::*;
    logic mclk = 1'b0;
    logic link_clk = 1'b0;
    logic arst_n = 1'b0;
    logic lrst_n = 1'b0;
    logic pwrdn = 1'b0;
    logic en = 1'b0;
    logic st_sync = 1'b0;
    logic st_sdo = 1'b0;
    logic [19:0] mono = 20'h00000;
    acl_pair_t adc = '0;
    acl_pair_t dac;
    acl_mode_t mode;
    logic sync, sdo, bclk, bclk_oe, sdin, sdin_oe, tick, clk_run;
    logic [15:0] tag;
    logic [19:0] in_l;
    logic [19:0] in_r;
    int bad_cnt;
    int error_cnt = 0;
    int checks = 0;
    int rises = 0;
    realtime t_rise = 0.0;
    realtime t_fall = 0.0;
    realtime hi_w = 0.0;
    realtime lo_w = 0.0;

    always #25 mclk = ~mclk;
    always #40 link_clk = ~link_clk;

    acl_link_ctrl acl_link_ctrl_inst (
        .MCLK_I(mclk), .ARST_N_I(arst_n), .LINK_CLK_I(link_clk), .LINK_RST_N_I(lrst_n),
        .SYNC_I(sync), .SDATA_OUT_I(sdo), .PWRDN_REQ_I(pwrdn), .ADC_I(adc),
        .BIT_CLK_O(bclk), .BIT_CLK_OE_O(bclk_oe), .SDATA_IN_O(sdin),
        .SDATA_IN_OE_O(sdin_oe), .DAC_O(dac), .SAMPLE_TICK_O(tick),
        .TEST_MODE_O(mode), .CLK_RUN_O(clk_run));

    acl_ctrl_model acl_ctrl_model_inst (
        .bit_clk_i(bclk), .oe_i(sdin_oe), .sdata_in_i(sdin), .en_i(en),
        .strap_sync_i(st_sync), .strap_sdo_i(st_sdo), .mono_i(mono),
        .sync_o(sync), .sdata_out_o(sdo), .tag_o(tag), .in_l_o(in_l), .in_r_o(in_r),
        .bad_cnt_o(bad_cnt));

    always @(posedge bclk) begin
        t_rise = $realtime;
        lo_w = t_rise - t_fall;
        rises++;
    end
    always @(negedge bclk) begin
        t_fall = $realtime;
        hi_w = t_fall - t_rise;
    end

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run;
        if (error_cnt == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic wait_rise(input int r0, output logic seen);
        seen = 1'b0;
        for (int i = 0; i < 40 && !seen; i++) begin
            @(posedge mclk);
            seen = rises != r0;
        end
    endtask

    task automatic tick_wait(output int n);
        n = 0;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (tick !== 1'b1 && n < 1000);
        if (n >= 1000) begin
            error_cnt++;
            complete_run;
        end
    endtask

    task automatic cold(input logic s, input logic d, input acl_mode_t m);
        realtime t_rel;
        int r0;
        logic seen;
        @(posedge mclk);
        en <= 1'b0;
        st_sync <= s;
        st_sdo <= d;
        lrst_n <= 1'b0;
        repeat (24) @(posedge mclk);
        check("mode in reset", mode, MODE_NORMAL);
        lrst_n <= 1'b1;
        t_rel = $realtime;
        r0 = rises;
        repeat (6) @(posedge mclk);
        st_sync <= 1'b0;
        st_sdo <= 1'b0;
        wait_rise(r0, seen);
        check("test mode", mode, m);
        check("clock started", seen, m != MODE_ATE);
        if (seen) check("reset to clock", t_rise - t_rel >= 162.8, 1'b1);
        check("clock run", clk_run, m != MODE_ATE);
        check("clock oe", bclk_oe, m != MODE_ATE);
        check("data oe", sdin_oe, m != MODE_ATE);
        @(posedge mclk);
        en <= m != MODE_ATE;
    endtask

    task automatic frames;
        int n;
        @(posedge mclk);
        mono <= 20'h5a3c1;
        adc <= {20'h12345, 20'habcde};
        tick_wait(n);
        tick_wait(n);
        tick_wait(n);
        check("frame period", n inside {[818:821]}, 1'b1);
        check("dac pair", dac, {mono, mono});
        // ready and both slot-valid flags, first tag bit in the msb
        check("inbound tag", tag, 64'h9800);
        check("inbound left", in_l, adc.left);
        check("inbound right", in_r, adc.right);
        check("clock high", hi_w >= 64.0 && hi_w <= 96.0, 1'b1);
        check("clock low", lo_w >= 64.0 && lo_w <= 96.0, 1'b1);
    endtask

    task automatic warm(input acl_mode_t m);
        realtime t_rel;
        int r0;
        logic seen;
        @(posedge mclk);
        en <= 1'b0;
        pwrdn <= 1'b1;
        @(posedge mclk);
        pwrdn <= 1'b0;
        repeat (20) @(posedge mclk);
        check("powered down", clk_run, 1'b0);
        st_sync <= 1'b1;
        repeat (10) @(posedge mclk);
        st_sync <= 1'b0;
        wait_rise(rises, seen);
        check("short sync", seen, 1'b0);
        st_sync <= 1'b1;
        repeat (26) @(posedge mclk);
        st_sync <= 1'b0;
        t_rel = $realtime;
        r0 = rises;
        wait_rise(r0, seen);
        check("warm restart", seen, 1'b1);
        check("sync to clock", t_rise - t_rel >= 162.8, 1'b1);
        check("mode kept", mode, m);
        @(posedge mclk);
        en <= 1'b1;
    endtask

    initial begin
        repeat (6) @(posedge mclk);
        arst_n <= 1'b1;
        cold(1'b0, 1'b0, MODE_NORMAL);
        frames;
        warm(MODE_NORMAL);
        cold(1'b0, 1'b1, MODE_ATE);
        cold(1'b0, 1'b0, MODE_NORMAL);
        cold(1'b1, 1'b0, MODE_VENDOR);
        warm(MODE_VENDOR);
        cold(1'b1, 1'b1, MODE_SCAN);
        cold(1'b0, 1'b0, MODE_NORMAL);
        frames;
        check("link timing", bad_cnt, 64'h0);
        complete_run;
    end
endmodule

//--- verilog/acl_cfg.svh
// link timing, slot layout and reset constants for the codec link block
// assumes a 20 MHz system clock and a link oscillator at twice the bit rate
`ifndef ACL_CFG_SVH
`define ACL_CFG_SVH

// slot layout, bit positions counted from the first tag bit of a frame
`define ACL_SLOT_BITS 20
`define ACL_SLOT_L_BASE 8'd56
`define ACL_SLOT_R_BASE 8'd76
`define ACL_TAG_READY 8'd0
`define ACL_TAG_VALID_L 8'd3
`define ACL_TAG_VALID_R 8'd4

// reset values
`define ACL_CNT_RST 5'h00
`define ACL_POS_RST 8'h00

// timing
// counts in 20 MHz system clocks: 162.8 ns rounds up to 4, a 1 us sync pulse is 20
`define ACL_RST_CLK_CYC 4
`define ACL_WARM_CYC 20

`endif

//--- verilog/acl_evt_xfer.sv
// single-cycle event crossing by toggle, source to destination clock
// assumes events are spaced by more than four destination cycles
`timescale 1ns/1ps

module acl_evt_xfer (
    input wire logic src_clk_i,
    input wire logic src_rst_n_i,
    input wire logic evt_i,
    input wire logic dst_clk_i,
    input wire logic dst_rst_n_i,
    output logic evt_o
);
    typedef struct packed {
        logic tog;
    } acl_xsrc_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic pulse;
    } acl_xdst_t;

    acl_xsrc_t src;
    acl_xsrc_t next_src;
    acl_xdst_t dst;
    acl_xdst_t next_dst;

    always_comb begin
        next_src.tog = src.tog ^ evt_i;
        next_dst.s1 = src.tog;
        next_dst.s2 = dst.s1;
        next_dst.s3 = dst.s2;
        next_dst.pulse = dst.s2 ^ dst.s3;
    end

    always_ff @(posedge src_clk_i or negedge src_rst_n_i) begin
        if (!src_rst_n_i) begin
            src <= '0;
        end else begin
            src <= next_src;
        end
    end

    always_ff @(posedge dst_clk_i or negedge dst_rst_n_i) begin
        if (!dst_rst_n_i) begin
            dst <= '0;
        end else begin
            dst <= next_dst;
        end
    end

    assign evt_o = dst.pulse;
endmodule

//--- verilog/acl_link_ctrl.sv
// codec end of a five-wire serial audio link: bit clock, framing, reset and test modes
// assumes LINK_CLK_I is a free-running oscillator at twice the bit rate; the
// controller owns sync, outbound data and the link reset pin
`timescale 1ns/1ps
`include "acl_cfg.svh"

module acl_link_ctrl
    import acl_pkg::*;
(
    input wire logic MCLK_I,
    input wire logic ARST_N_I,
    input wire logic LINK_CLK_I,
    input wire logic LINK_RST_N_I,
    input wire logic SYNC_I,
    input wire logic SDATA_OUT_I,
    input wire logic PWRDN_REQ_I,
    input wire acl_pair_t ADC_I,
    output logic BIT_CLK_O,
    output logic BIT_CLK_OE_O,
    output logic SDATA_IN_O,
    output logic SDATA_IN_OE_O,
    output acl_pair_t DAC_O,
    output logic SAMPLE_TICK_O,
    output acl_mode_t TEST_MODE_O,
    output logic CLK_RUN_O
);
    acl_main_t m;
    acl_main_t next_m;
    acl_link_t l;
    acl_link_t next_l;

    logic rst_s;
    logic sy_m;
    logic sdo_m;
    logic sy_l;
    logic sdo_l;
    logic run_l;
    logic hiz_l;
    logic evt_m;
    // sync reaches the link logic one bit late, so inbound bits launch one position ahead
    logic [7:0] tx_pos;

    function automatic logic in_slot(input logic [7:0] pos, input logic [7:0] base);
        in_slot = (pos >= base) && (pos < 8'(base + `ACL_SLOT_BITS));
    endfunction

    // slot words go out most significant bit first
    function automatic logic slot_bit(input logic [`ACL_SLOT_BITS-1:0] word,
                                      input logic [7:0] pos, input logic [7:0] base);
        logic [7:0] idx;
        idx = 8'(base + `ACL_SLOT_BITS - 1) - pos;
        slot_bit = word[idx[4:0]];
    endfunction

    // ---------------- system clock side ----------------

    acl_sync2 #(
        .W(3)
    ) u_sync_main (
        .clk_i(MCLK_I),
        .rst_n_i(ARST_N_I),
        .d_i({LINK_RST_N_I, SYNC_I, SDATA_OUT_I}),
        .q_o({rst_s, sy_m, sdo_m})
    );

    always_comb begin
        next_m = m;
        next_m.tick = 1'b0;
        // link hold words stay put for a whole frame after the event, so a
        // copy on the crossed pulse is safe; adc words are likewise held a frame
        if (evt_m) begin
            next_m.tick = 1'b1;
            next_m.dac = l.dac;
            next_m.adc = ADC_I;
        end
        if (!rst_s) begin
            // cold reset is the only path out of a test mode
            next_m.st = ST_RESET;
            next_m.mode = MODE_NORMAL;
            next_m.run = 1'b0;
            next_m.hiz = 1'b0;
            next_m.cnt = `ACL_CNT_RST;
        end else begin
            case (m.st)
                ST_RESET: begin
                    // first cycle after release: straps are latched here
                    next_m.cnt = `ACL_CNT_RST;
                    next_m.st = ST_DELAY;
                    if (sdo_m && sy_m) begin
                        next_m.mode = MODE_SCAN;
                    end else if (sdo_m) begin
                        next_m.mode = MODE_ATE;
                        next_m.hiz = 1'b1;
                        next_m.st = ST_HIZ;
                    end else if (sy_m) begin
                        next_m.mode = MODE_VENDOR;
                    end else begin
                        next_m.mode = MODE_NORMAL;
                    end
                end
                ST_DELAY: begin
                    next_m.cnt = 5'(m.cnt + 1);
                    if (m.cnt == 5'(`ACL_RST_CLK_CYC - 1)) begin
                        next_m.st = ST_RUN;
                        next_m.run = 1'b1;
                    end
                end
                ST_RUN: begin
                    if (PWRDN_REQ_I) begin
                        next_m.st = ST_STOP;
                        next_m.run = 1'b0;
                    end
                end
                ST_STOP: begin
                    if (sy_m) begin
                        next_m.st = ST_WARM;
                        next_m.cnt = `ACL_CNT_RST;
                    end
                end
                ST_WARM: begin
                    // a sync pulse shorter than the minimum is not a wake-up
                    if (sy_m) begin
                        if (m.cnt != 5'(`ACL_WARM_CYC - 1)) begin
                            next_m.cnt = 5'(m.cnt + 1);
                        end
                    end else if (m.cnt == 5'(`ACL_WARM_CYC - 1)) begin
                        next_m.st = ST_DELAY;
                        next_m.cnt = `ACL_CNT_RST;
                    end else begin
                        next_m.st = ST_STOP;
                    end
                end
                ST_HIZ: begin
                    next_m.run = 1'b0;
                end
                default: begin
                    next_m.st = ST_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            m <= '0;
        end else begin
            m <= next_m;
        end
    end

    // ---------------- link clock side ----------------

    acl_sync2 #(
        .W(4)
    ) u_sync_link (
        .clk_i(LINK_CLK_I),
        .rst_n_i(ARST_N_I),
        .d_i({SYNC_I, SDATA_OUT_I, m.run, m.hiz}),
        .q_o({sy_l, sdo_l, run_l, hiz_l})
    );

    assign tx_pos = 8'(l.cnt + 8'd1);

    always_comb begin
        next_l = l;
        next_l.evt = 1'b0;
        // vendor and scan modes leave both drivers on
        next_l.bclk_oe = !hiz_l;
        next_l.sdin_oe = !hiz_l;
        if (!run_l) begin
            // clock parks low; a high phase is never cut short since it lasts one cycle
            next_l.bclk = 1'b0;
            // inbound data holds through the last fall so its hold time is kept
            next_l.sdin = l.bclk ? l.sdin : 1'b0;
            next_l.prev_sync = 1'b0;
        end else begin
            next_l.bclk = !l.bclk;
            if (l.bclk) begin
                // falling edge: sample sync and outbound data
                next_l.prev_sync = sy_l;
                if (sy_l && !l.prev_sync) begin
                    // the bit sampled at this fall is position 0 itself
                    next_l.cnt = 8'(`ACL_POS_RST + 8'd1);
                end else begin
                    next_l.cnt = 8'(l.cnt + 1);
                    if (in_slot(l.cnt, `ACL_SLOT_L_BASE)) begin
                        next_l.l_sh = {l.l_sh[`ACL_SLOT_BITS-2:0], sdo_l};
                    end
                    if (in_slot(l.cnt, `ACL_SLOT_R_BASE)) begin
                        next_l.r_sh = {l.r_sh[`ACL_SLOT_BITS-2:0], sdo_l};
                    end
                    if (l.cnt == 8'(`ACL_SLOT_R_BASE + `ACL_SLOT_BITS - 1)) begin
                        next_l.dac.left = l.l_sh;
                        next_l.dac.right = {l.r_sh[`ACL_SLOT_BITS-2:0], sdo_l};
                        next_l.evt = 1'b1;
                    end
                end
            end else begin
                // rising edge: launch the bit the controller samples next fall
                if (tx_pos == `ACL_TAG_READY || tx_pos == `ACL_TAG_VALID_L ||
                    tx_pos == `ACL_TAG_VALID_R) begin
                    next_l.sdin = 1'b1;
                end else if (in_slot(tx_pos, `ACL_SLOT_L_BASE)) begin
                    next_l.sdin = slot_bit(m.adc.left, tx_pos, `ACL_SLOT_L_BASE);
                end else if (in_slot(tx_pos, `ACL_SLOT_R_BASE)) begin
                    next_l.sdin = slot_bit(m.adc.right, tx_pos, `ACL_SLOT_R_BASE);
                end else begin
                    next_l.sdin = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge LINK_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    acl_evt_xfer u_frame_evt (
        .src_clk_i(LINK_CLK_I),
        .src_rst_n_i(ARST_N_I),
        .evt_i(l.evt),
        .dst_clk_i(MCLK_I),
        .dst_rst_n_i(ARST_N_I),
        .evt_o(evt_m)
    );

    assign BIT_CLK_O = l.bclk;
    assign BIT_CLK_OE_O = l.bclk_oe;
    assign SDATA_IN_O = l.sdin;
    assign SDATA_IN_OE_O = l.sdin_oe;
    assign DAC_O = m.dac;
    assign SAMPLE_TICK_O = m.tick;
    assign TEST_MODE_O = m.mode;
    assign CLK_RUN_O = m.run;

    // ---------------- checks ----------------

    sequence s_settle;
        rst_s [*5];
    endsequence

    sequence s_warm_end;
        (m.st == ST_WARM) && !sy_m && (m.cnt == 5'(`ACL_WARM_CYC - 1));
    endsequence

    property p_cold_start;
        @(posedge MCLK_I) disable iff (!ARST_N_I)
        $rose(rst_s) && !(sdo_m && !sy_m) ##1 s_settle |-> m.run && !$past(m.run);
    endproperty
    a_cold_start: assert property (p_cold_start) else $error("bit clock start timing");

    property p_warm_start;
        @(posedge MCLK_I) disable iff (!ARST_N_I)
        s_warm_end ##1 s_settle |-> m.run && !$past(m.run);
    endproperty
    a_warm_start: assert property (p_warm_start) else $error("warm restart timing");

    property p_warm_short;
        @(posedge MCLK_I) disable iff (!ARST_N_I)
        (m.st == ST_WARM) && !sy_m && (m.cnt != 5'(`ACL_WARM_CYC - 1)) && rst_s
        |=> (m.st == ST_STOP) && !m.run;
    endproperty
    a_warm_short: assert property (p_warm_short) else $error("short sync woke codec");

    property p_ate;
        @(posedge MCLK_I) disable iff (!ARST_N_I)
        $rose(rst_s) && sdo_m && !sy_m |=> (m.mode == MODE_ATE) && m.hiz && !m.run;
    endproperty
    a_ate: assert property (p_ate) else $error("ATE mode not latched");

    property p_ate_stop;
        @(posedge MCLK_I) disable iff (!ARST_N_I)
        (m.mode == MODE_ATE) |-> !m.run && m.hiz;
    endproperty
    a_ate_stop: assert property (p_ate_stop) else $error("ATE mode ran the bit clock");

    property p_vendor;
        @(posedge MCLK_I) disable iff (!ARST_N_I)
        $rose(rst_s) && sy_m && !sdo_m |=> (m.mode == MODE_VENDOR) && !m.hiz;
    endproperty
    a_vendor: assert property (p_vendor) else $error("vendor mode not latched");

    property p_scan;
        @(posedge MCLK_I) disable iff (!ARST_N_I)
        $rose(rst_s) && sy_m && sdo_m |=> (m.mode == MODE_SCAN) && !m.hiz;
    endproperty
    a_scan: assert property (p_scan) else $error("scan mode not latched");

    property p_mode_keep;
        @(posedge MCLK_I) disable iff (!ARST_N_I)
        rst_s && $past(rst_s, 2) && $past(rst_s) |-> $stable(m.mode);
    endproperty
    a_mode_keep: assert property (p_mode_keep) else $error("mode changed without reset");

    property p_tick;
        @(posedge MCLK_I) disable iff (!ARST_N_I)
        m.tick |=> !m.tick && (m.dac == $past(l.dac, 2));
    endproperty
    a_tick: assert property (p_tick) else $error("sample tick malformed");

    property p_duty;
        @(posedge LINK_CLK_I) disable iff (!ARST_N_I)
        $rose(l.bclk) |=> $fell(l.bclk);
    endproperty
    a_duty: assert property (p_duty) else $error("bit clock high phase wrong");

    property p_launch;
        @(posedge LINK_CLK_I) disable iff (!ARST_N_I)
        $changed(l.sdin) && $past(run_l) |-> $rose(l.bclk);
    endproperty
    a_launch: assert property (p_launch) else $error("inbound data moved off rising edge");

    property p_hiz;
        @(posedge LINK_CLK_I) disable iff (!ARST_N_I)
        hiz_l ##1 hiz_l |-> !l.bclk_oe && !l.sdin_oe && !l.bclk;
    endproperty
    a_hiz: assert property (p_hiz) else $error("link outputs not floated");

    property p_drive;
        @(posedge LINK_CLK_I) disable iff (!ARST_N_I)
        !hiz_l |=> l.bclk_oe && l.sdin_oe;
    endproperty
    a_drive: assert property (p_drive) else $error("link outputs not driven");

    property p_frame;
        @(posedge LINK_CLK_I) disable iff (!ARST_N_I)
        l.evt |-> l.cnt == 8'(`ACL_SLOT_R_BASE + `ACL_SLOT_BITS);
    endproperty
    a_frame: assert property (p_frame) else $error("frame event misplaced");
endmodule

//--- verilog/acl_pkg.sv
// types shared by the codec link block
// assumes acl_cfg.svh is on the include path
`include "acl_cfg.svh"

package acl_pkg;
    typedef enum logic [1:0] {MODE_NORMAL, MODE_ATE, MODE_VENDOR, MODE_SCAN} acl_mode_t;
    typedef enum logic [2:0] {ST_RESET, ST_DELAY, ST_RUN, ST_STOP, ST_WARM, ST_HIZ} acl_state_t;

    typedef struct packed {
        logic [`ACL_SLOT_BITS-1:0] left;
        logic [`ACL_SLOT_BITS-1:0] right;
    } acl_pair_t;

    typedef struct packed {
        acl_state_t st;
        logic [4:0] cnt;
        acl_mode_t mode;
        logic run;
        logic hiz;
        logic tick;
        acl_pair_t dac;
        acl_pair_t adc;
    } acl_main_t;

    typedef struct packed {
        logic bclk;
        logic bclk_oe;
        logic sdin;
        logic sdin_oe;
        logic [7:0] cnt;
        logic prev_sync;
        logic [`ACL_SLOT_BITS-1:0] l_sh;
        logic [`ACL_SLOT_BITS-1:0] r_sh;
        acl_pair_t dac;
        logic evt;
    } acl_link_t;
endpackage

//--- verilog/acl_sync2.sv
// two-flop level synchroniser, W bits wide
// assumes each bit is an independent level; no multi-bit coherence
`timescale 1ns/1ps

module acl_sync2 #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } acl_sync_t;

    acl_sync_t s;
    acl_sync_t next_s;

    always_comb begin
        next_s.s1 = d_i;
        next_s.s2 = s.s1;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign q_o = s.s2;
endmodule
